// *** hdl/sdrv_pkg.sv ***
// Purpose: Shared constants for the stepper driver serial register bank
// Assumes: 20-bit command and response words, most significant bit first
// Notes:   Field constants give the low bit and the width of each multi-bit field, and the bit of each single-bit field
package sdrv_pkg;
   localparam int unsigned WORD_W = 20;
   localparam int unsigned SYNC_W = 3;
   // Synchroniser lanes
   localparam int unsigned LANE_SDI = 0, LANE_SCK = 1, LANE_CS = 2;
   // Address decode
   localparam int unsigned ADR2_LSB = 18, ADR3_LSB = 17;
   localparam logic [1:0] ADR_DRV_CTRL = 2'b00;
   localparam logic [2:0] ADR_CHOP = 3'b100;
   localparam logic [2:0] ADR_ACUR = 3'b101;
   localparam logic [2:0] ADR_LOAD = 3'b110;
   localparam logic [2:0] ADR_DCFG = 3'b111;
   localparam int unsigned CTRL_W = 18;
   // Driver control, direct coil current form
   localparam int unsigned COIL_A_POL_B = 17, COIL_A_MAG_LSB = 9, COIL_B_POL_B = 8;
   localparam int unsigned COIL_B_MAG_LSB = 0, MAG_W = 8;
   // Driver control, step interface form
   localparam int unsigned INTERP_B = 9, BOTH_EDGES_B = 8, RES_LSB = 0, RES_W = 4;
   // Chopper config
   localparam int unsigned BLANK_LSB = 15, BLANK_W = 2, CHOP_MODE_B = 14, RAND_OFF_B = 13;
   localparam int unsigned HYST_DEC_LSB = 11, HYST_DEC_W = 2, HYST_END_LSB = 7, HYST_END_W = 4;
   localparam int unsigned HYST_START_LSB = 4, HYST_START_W = 3;
   localparam int unsigned OFF_TIME_LSB = 0, OFF_TIME_W = 4;
   // Adaptive current config
   localparam int unsigned IMIN_B = 15, DN_LSB = 13, DN_W = 2, UTH_LSB = 8, UTH_W = 4;
   localparam int unsigned UP_LSB = 5, UP_W = 2, LTH_LSB = 0, LTH_W = 4;
   // Load detect config
   localparam int unsigned FILT_B = 16, THR_LSB = 8, THR_W = 7, CS_LSB = 0, CS_W = 5;
   // Driver config
   localparam int unsigned TEST_B = 16, HS_SLOPE_LSB = 14, LS_SLOPE_LSB = 12, SLOPE_W = 2;
   localparam int unsigned S2G_DIS_B = 10, SHORT_TMR_LSB = 8, SHORT_TMR_W = 2, STEP_OFF_B = 7;
   localparam int unsigned SENSE_SEL_B = 6, READ_SEL_LSB = 4, READ_SEL_W = 2;
   // Response formats
   localparam logic [1:0] RS_POSITION = 2'b00;
   localparam logic [1:0] RS_LOAD = 2'b01;
   localparam logic [1:0] RS_LOAD_LEVEL = 2'b10;
   localparam int unsigned RSP_HI_LSB = 10, RSP_HI_W = 10;
   localparam int unsigned RSP_LOADHI_LSB = 15, RSP_LOADHI_W = 5, LEVEL_W = 5;
   localparam int unsigned FLAGS_W = 8;
   localparam logic [WORD_W-1:0] WORD_ZERO = 20'h00000;
endpackage

// *** hdl/sdrv_pin_sync.sv ***
// Purpose: Two-flop synchronisers with edge pulses for the serial pins
// Assumes: Inputs are asynchronous to clk_i
// Notes:   First stage is read only by the second stage
`timescale 1ns/1ps
module sdrv_pin_sync #(
   parameter int unsigned N = 3
) (
   input  wire logic         clk_i,
   input  wire logic         rst_n_i,
   input  wire logic [N-1:0] async_i,
   output logic      [N-1:0] level_o,
   output logic      [N-1:0] rise_o,
   output logic      [N-1:0] fall_o
);
   logic [N-1:0] meta_q;
   logic [N-1:0] sync_q;
   logic [N-1:0] prev_q;

   for (genvar i = 0; i < N; i++) begin : g_lane
      always_ff @(posedge clk_i) begin
         if (!rst_n_i) begin
            meta_q[i] <= 1'b1;
            sync_q[i] <= 1'b1;
            prev_q[i] <= 1'b1;
         end else begin
            meta_q[i] <= async_i[i];
            sync_q[i] <= meta_q[i];
            prev_q[i] <= sync_q[i];
         end
      end
      assign level_o[i] = sync_q[i];
      assign rise_o[i]  = sync_q[i] & ~prev_q[i];
      assign fall_o[i]  = ~sync_q[i] & prev_q[i];
   end
endmodule

// *** hdl/sdrv_spi_regs.sv ***
// Purpose: Serial command decode and configuration storage of a stepper driver
// Assumes: Serial clock at most a quarter of clk_i; status inputs on clk_i
// Notes:   Registers are write-only; response word is chosen by read select
//
// Behaviour
// [R1] Every transaction with a mapped address is a write to one of five write-only registers.
// [R2] Top address bits select driver control or one of four config registers.
// [R3] Step interface off: driver control writes set both coil currents directly.
// [R4] Step interface on: driver control writes configure the step interface.
// [R5] Coil form: A polarity 17, A magnitude 16:9, B polarity 8, B magnitude 7:0.
// [R6] Step form: interpolation 9, both edges 8, resolution code 3:0.
// [R7] Chopper fields: blanking, mode, random off, hysteresis fields, off time.
// [R8] Adaptive current fields: minimum, decrement, upper, increment, lower threshold.
// [R9] Load detect fields: filter enable 16, threshold 14:8, current scale 4:0.
// [R10] Driver config: test, slopes, short controls, step off, sense, read select.
// [R11] Master writes fixed-zero bits as zero and fixed-one bits as one.
// [R12] Read select 01 returns load value; 10 returns load top and level.
// [R13] Read select 00 returns position in 19:10 and status flags in 7:0.
// [R14] Shifted word is committed only when chip select returns high.
// [R15] Only the last twenty bits before chip select rises are decoded.
// [R16] Command and response words travel most significant bit first.
// [R17] Undefined response bits are zero; registers hold until overwritten.
`timescale 1ns/1ps
module sdrv_spi_regs (
   input  wire logic                 clk_i,
   input  wire logic                 rst_n_i,
   input  wire logic                 sck_i,
   input  wire logic                 sdi_i,
   input  wire logic                 chip_select_low_n_i,
   output logic                      sdo_o,
   output logic                      sdo_oe_n_o,
   input  wire logic [9:0]           microstep_position_i,
   input  wire logic [9:0]           load_value_i,
   input  wire logic [4:0]           adaptive_current_level_i,
   input  wire logic                 standstill_flag_i,
   input  wire logic                 open_load_b_i,
   input  wire logic                 open_load_a_i,
   input  wire logic                 short_b_i,
   input  wire logic                 short_a_i,
   input  wire logic                 overtemp_warning_i,
   input  wire logic                 overtemp_shutdown_i,
   input  wire logic                 stall_flag_i,
   output logic                      coil_a_polarity_o,
   output logic [7:0]                coil_a_magnitude_o,
   output logic                      coil_b_polarity_o,
   output logic [7:0]                coil_b_magnitude_o,
   output logic                      step_interpolation_enable_o,
   output logic                      both_edges_active_o,
   output logic [3:0]                microstep_resolution_o,
   output logic [1:0]                blanking_time_o,
   output logic                      chopper_mode_o,
   output logic                      random_off_time_o,
   output logic [1:0]                hysteresis_decrement_o,
   output logic [3:0]                hysteresis_end_o,
   output logic [2:0]                hysteresis_start_o,
   output logic [3:0]                off_time_o,
   output logic                      minimum_current_select_o,
   output logic [1:0]                decrement_speed_o,
   output logic [3:0]                upper_threshold_o,
   output logic [1:0]                increment_speed_o,
   output logic [3:0]                lower_threshold_o,
   output logic                      load_filter_enable_o,
   output logic [6:0]                load_threshold_o,
   output logic [4:0]                current_scale_o,
   output logic                      test_bit_o,
   output logic [1:0]                high_side_slope_o,
   output logic [1:0]                low_side_slope_o,
   output logic                      short_to_ground_disable_o,
   output logic [1:0]                short_timer_o,
   output logic                      step_interface_off_o,
   output logic                      sense_voltage_select_o,
   output logic [1:0]                read_select_o
);
   localparam int unsigned W = sdrv_pkg::WORD_W;

   logic [sdrv_pkg::SYNC_W-1:0] pin_lvl;
   logic [sdrv_pkg::SYNC_W-1:0] pin_rise;
   logic [sdrv_pkg::SYNC_W-1:0] pin_fall;
   logic                        sdi_s;
   logic                        cs_act;
   logic                        cs_begin;
   logic                        cs_end;
   logic                        sck_up;
   logic                        sck_dn;
   logic [W-1:0]                shift_q;
   logic                        sdo_q;
   logic [sdrv_pkg::CTRL_W-1:0] coil_q;
   logic [sdrv_pkg::CTRL_W-1:0] step_q;
   logic [W-1:0]                chop_q;
   logic [W-1:0]                acur_q;
   logic [W-1:0]                load_q;
   logic [W-1:0]                dcfg_q;
   logic [W-1:0]                resp;
   logic [1:0]                  adr2;
   logic [2:0]                  adr3;
   logic                        sd_off;
   logic [1:0]                  read_sel;
   logic [sdrv_pkg::FLAGS_W-1:0] flags;

   sdrv_pin_sync #(
      .N (sdrv_pkg::SYNC_W)
   ) u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .async_i ({chip_select_low_n_i, sck_i, sdi_i}),
      .level_o (pin_lvl),
      .rise_o  (pin_rise),
      .fall_o  (pin_fall)
   );

   assign sdi_s    = pin_lvl[sdrv_pkg::LANE_SDI];
   assign cs_act   = ~pin_lvl[sdrv_pkg::LANE_CS];
   assign cs_begin = pin_fall[sdrv_pkg::LANE_CS];
   assign cs_end   = pin_rise[sdrv_pkg::LANE_CS];
   assign sck_up   = pin_rise[sdrv_pkg::LANE_SCK] & cs_act;
   assign sck_dn   = pin_fall[sdrv_pkg::LANE_SCK] & cs_act;
   assign adr2     = shift_q[W-1:sdrv_pkg::ADR2_LSB];
   assign adr3     = shift_q[W-1:sdrv_pkg::ADR3_LSB];
   assign sd_off   = dcfg_q[sdrv_pkg::STEP_OFF_B];
   assign read_sel = dcfg_q[sdrv_pkg::READ_SEL_LSB +: sdrv_pkg::READ_SEL_W];
   assign flags    = {standstill_flag_i, open_load_b_i, open_load_a_i, short_b_i,
                      short_a_i, overtemp_warning_i, overtemp_shutdown_i, stall_flag_i};

   // [R12] Response format select
   always_comb begin
      resp = sdrv_pkg::WORD_ZERO;
      case (read_sel)
         sdrv_pkg::RS_POSITION: begin
            // [R13] Position and flags
            resp[sdrv_pkg::RSP_HI_LSB +: sdrv_pkg::RSP_HI_W] = microstep_position_i;
            resp[sdrv_pkg::FLAGS_W-1:0] = flags;
         end
         sdrv_pkg::RS_LOAD: begin
            resp[sdrv_pkg::RSP_HI_LSB +: sdrv_pkg::RSP_HI_W] = load_value_i;
         end
         sdrv_pkg::RS_LOAD_LEVEL: begin
            resp[sdrv_pkg::RSP_LOADHI_LSB +: sdrv_pkg::RSP_LOADHI_W] =
               load_value_i[sdrv_pkg::RSP_HI_W-1 -: sdrv_pkg::RSP_LOADHI_W];
            resp[sdrv_pkg::RSP_HI_LSB +: sdrv_pkg::LEVEL_W] = adaptive_current_level_i;
         end
         // [R17] Undefined format reads zero
         default: resp = sdrv_pkg::WORD_ZERO;
      endcase
   end

   // [R16] Shift register, MSB first
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         shift_q <= sdrv_pkg::WORD_ZERO;
      end else if (cs_begin) begin
         shift_q <= resp;
      end else if (sck_up) begin
         // [R15] Older bits fall off the top
         shift_q <= {shift_q[W-2:0], sdi_s};
      end
   end

   // Serial output updated after falling clock
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         sdo_q <= 1'b0;
      end else if (cs_begin) begin
         sdo_q <= resp[W-1];
      end else if (sck_dn) begin
         sdo_q <= shift_q[W-1];
      end
   end

   assign sdo_o      = sdo_q;
   assign sdo_oe_n_o = ~cs_act;

   // [R14] Commit on chip select release
   // [R1] Address decode to write-only storage
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         coil_q <= '0;
         step_q <= '0;
      end else if (cs_end && adr2 == sdrv_pkg::ADR_DRV_CTRL) begin
         // [R3] Direct coil form
         if (sd_off) begin
            coil_q <= shift_q[sdrv_pkg::CTRL_W-1:0];
         // [R4] Step interface form
         end else begin
            step_q <= shift_q[sdrv_pkg::CTRL_W-1:0];
         end
      end
   end

   // [R2] Config register select
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         chop_q <= sdrv_pkg::WORD_ZERO;
         acur_q <= sdrv_pkg::WORD_ZERO;
         load_q <= sdrv_pkg::WORD_ZERO;
         dcfg_q <= sdrv_pkg::WORD_ZERO;
      end else if (cs_end) begin
         case (adr3)
            sdrv_pkg::ADR_CHOP: chop_q <= shift_q;
            sdrv_pkg::ADR_ACUR: acur_q <= shift_q;
            sdrv_pkg::ADR_LOAD: load_q <= shift_q;
            sdrv_pkg::ADR_DCFG: dcfg_q <= shift_q;
            default: ;
         endcase
      end
   end

   // [R5] Coil current fields
   assign coil_a_polarity_o  = coil_q[sdrv_pkg::COIL_A_POL_B];
   assign coil_a_magnitude_o = coil_q[sdrv_pkg::COIL_A_MAG_LSB +: sdrv_pkg::MAG_W];
   assign coil_b_polarity_o  = coil_q[sdrv_pkg::COIL_B_POL_B];
   assign coil_b_magnitude_o = coil_q[sdrv_pkg::COIL_B_MAG_LSB +: sdrv_pkg::MAG_W];
   // [R6] Step interface fields
   assign step_interpolation_enable_o = step_q[sdrv_pkg::INTERP_B];
   assign both_edges_active_o         = step_q[sdrv_pkg::BOTH_EDGES_B];
   assign microstep_resolution_o      = step_q[sdrv_pkg::RES_LSB +: sdrv_pkg::RES_W];
   // [R7] Chopper fields
   assign blanking_time_o        = chop_q[sdrv_pkg::BLANK_LSB +: sdrv_pkg::BLANK_W];
   assign chopper_mode_o         = chop_q[sdrv_pkg::CHOP_MODE_B];
   assign random_off_time_o      = chop_q[sdrv_pkg::RAND_OFF_B];
   assign hysteresis_decrement_o = chop_q[sdrv_pkg::HYST_DEC_LSB +: sdrv_pkg::HYST_DEC_W];
   assign hysteresis_end_o       = chop_q[sdrv_pkg::HYST_END_LSB +: sdrv_pkg::HYST_END_W];
   assign hysteresis_start_o     = chop_q[sdrv_pkg::HYST_START_LSB +: sdrv_pkg::HYST_START_W];
   assign off_time_o             = chop_q[sdrv_pkg::OFF_TIME_LSB +: sdrv_pkg::OFF_TIME_W];
   // [R8] Adaptive current fields
   assign minimum_current_select_o = acur_q[sdrv_pkg::IMIN_B];
   assign decrement_speed_o        = acur_q[sdrv_pkg::DN_LSB +: sdrv_pkg::DN_W];
   assign upper_threshold_o        = acur_q[sdrv_pkg::UTH_LSB +: sdrv_pkg::UTH_W];
   assign increment_speed_o        = acur_q[sdrv_pkg::UP_LSB +: sdrv_pkg::UP_W];
   assign lower_threshold_o        = acur_q[sdrv_pkg::LTH_LSB +: sdrv_pkg::LTH_W];
   // [R9] Load detect fields
   assign load_filter_enable_o = load_q[sdrv_pkg::FILT_B];
   assign load_threshold_o     = load_q[sdrv_pkg::THR_LSB +: sdrv_pkg::THR_W];
   assign current_scale_o      = load_q[sdrv_pkg::CS_LSB +: sdrv_pkg::CS_W];
   // [R10] Driver config fields
   assign test_bit_o                = dcfg_q[sdrv_pkg::TEST_B];
   assign high_side_slope_o         = dcfg_q[sdrv_pkg::HS_SLOPE_LSB +: sdrv_pkg::SLOPE_W];
   assign low_side_slope_o          = dcfg_q[sdrv_pkg::LS_SLOPE_LSB +: sdrv_pkg::SLOPE_W];
   assign short_to_ground_disable_o = dcfg_q[sdrv_pkg::S2G_DIS_B];
   assign short_timer_o             = dcfg_q[sdrv_pkg::SHORT_TMR_LSB +: sdrv_pkg::SHORT_TMR_W];
   assign step_interface_off_o      = sd_off;
   assign sense_voltage_select_o    = dcfg_q[sdrv_pkg::SENSE_SEL_B];
   assign read_select_o             = read_sel;

   a_coil_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R3]
      cs_end && adr2 == 2'b00 && sd_off |=> coil_q == $past(shift_q[17:0]) && $stable(step_q))
      else $error("coil write not taken");
   a_step_write: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R4]
      cs_end && adr2 == 2'b00 && !sd_off |=> step_q == $past(shift_q[17:0]) && $stable(coil_q))
      else $error("step form write not taken");
   a_chop_select: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R2]
      cs_end && adr3 == 3'b100 |=> chop_q == $past(shift_q) && $stable(acur_q)
      && $stable(load_q) && $stable(dcfg_q))
      else $error("chopper select wrong");
   a_hold_midframe: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R14]
      !cs_end |=> $stable(chop_q) && $stable(acur_q) && $stable(load_q)
      && $stable(dcfg_q) && $stable(coil_q) && $stable(step_q))
      else $error("register changed outside commit");
   a_bad_addr: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R1]
      cs_end && adr2 == 2'b01 |=> $stable(coil_q) && $stable(step_q))
      else $error("unmapped address wrote driver control");
   a_shift_msb: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R16]
      sck_up && !cs_begin |=> shift_q[0] == $past(sdi_s)
      && shift_q[19:1] == $past(shift_q[18:0]))
      else $error("shift order wrong");
   a_resp_load: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R12]
      cs_begin && read_sel == 2'b10 |=> shift_q[19:15] == $past(load_value_i[9:5])
      && shift_q[14:10] == $past(adaptive_current_level_i) && shift_q[9:0] == 10'h000)
      else $error("load level response wrong");
   a_resp_status: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R13]
      cs_begin && read_sel == 2'b00 |=> shift_q[7:0] == $past(flags)
      && shift_q[9:8] == 2'b00 && shift_q[19:10] == $past(microstep_position_i))
      else $error("status response wrong");
   a_resp_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R17]
      cs_begin && read_sel == 2'b11 |=> shift_q == 20'h00000 && sdo_q == 1'b0)
      else $error("undefined response not zero");
   a_sdo_first: assert property (@(posedge clk_i) disable iff (!rst_n_i) // [R16]
      cs_begin ##1 (cs_act && !sck_dn && !sck_up)[*2] |-> sdo_q == shift_q[19])
      else $error("first response bit not on output");
endmodule

// *** testbench/sdrv_spi_master.sv ***
// Purpose: Serial bus master model that drives the register bank pins
// Assumes: Link clock period of 64 ns; link clock rests low between frames
// Notes:   The testbench calls the tasks; data line is inverted once a frame ends
`timescale 1ns/1ps
module sdrv_spi_master (
   output logic      sck_o,
   output logic      sdi_o,
   output logic      cs_n_o,
   input  wire logic sdo_i
);
   initial begin
      sck_o = 1'b0;
      sdi_o = 1'b0;
      cs_n_o = 1'b1;
   end

   task cs_low();
      cs_n_o <= 1'b0;
      #40;
   endtask

   task xfer(input logic [31:0] d, input int n, output logic [31:0] r);
      r = '0;
      for (int i = n - 1; i >= 0; i--) begin
         sdi_o <= d[i];
         #32;
         sck_o <= 1'b1;
         r = {r[30:0], sdo_i};
         #32;
         sck_o <= 1'b0;
      end
   endtask

   task cs_high();
      #32;
      cs_n_o <= 1'b1;
      sdi_o <= ~sdi_o;
      #40;
   endtask
endmodule

// *** testbench/testbench.sv ***
// Purpose: Self-checking bench for the serial register bank
// Assumes: 200 MHz system clock; serial frames come from the master model
// Notes:   Expected register words are kept here from the commands sent
`timescale 1ns/1ps
`define CHK(nm, ex, got) \
   begin \
      cmp_count++; \
      if ((got) !== (ex)) begin \
         error_cnt++; \
         $display("ERROR %s expected %h seen %h", nm, ex, got); \
      end \
   end
module testbench;
   logic        clk;
   logic        rst_n = 1'b0;
   logic        sck, sdi, cs_pin_n, sdo, sdo_oe_n;
   logic [9:0]  pos = 10'h000;
   logic [9:0]  ld = 10'h000;
   logic [4:0]  lvl = 5'h00;
   logic [7:0]  flags = 8'h00;
   wire  [17:0] coil;
   wire  [5:0]  stp;
   wire  [16:0] chop;
   wire  [12:0] acur, load;
   wire  [11:0] dcfg;
   logic [19:0] e_coil = '0, e_step = '0, e_chop = '0, e_acur = '0, e_load = '0, e_dcfg = '0;
   logic [31:0] rsp;
   int          error_cnt = 0;
   int          cmp_count = 0;

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Released data line shows the inverse of the last bit
   sdrv_spi_master m (
      .sck_o  (sck),
      .sdi_o  (sdi),
      .cs_n_o (cs_pin_n),
      .sdo_i  (sdo_oe_n ? ~sdo : sdo)
   );

   sdrv_spi_regs dut (
      .clk_i(clk), .rst_n_i(rst_n), .sck_i(sck), .sdi_i(sdi),
      .chip_select_low_n_i(cs_pin_n), .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n),
      .microstep_position_i(pos), .load_value_i(ld), .adaptive_current_level_i(lvl),
      .standstill_flag_i(flags[7]), .open_load_b_i(flags[6]), .open_load_a_i(flags[5]),
      .short_b_i(flags[4]), .short_a_i(flags[3]), .overtemp_warning_i(flags[2]),
      .overtemp_shutdown_i(flags[1]), .stall_flag_i(flags[0]),
      .coil_a_polarity_o(coil[17]), .coil_a_magnitude_o(coil[16:9]),
      .coil_b_polarity_o(coil[8]), .coil_b_magnitude_o(coil[7:0]),
      .step_interpolation_enable_o(stp[5]), .both_edges_active_o(stp[4]),
      .microstep_resolution_o(stp[3:0]),
      .blanking_time_o(chop[16:15]), .chopper_mode_o(chop[14]), .random_off_time_o(chop[13]),
      .hysteresis_decrement_o(chop[12:11]), .hysteresis_end_o(chop[10:7]),
      .hysteresis_start_o(chop[6:4]), .off_time_o(chop[3:0]),
      .minimum_current_select_o(acur[12]), .decrement_speed_o(acur[11:10]),
      .upper_threshold_o(acur[9:6]), .increment_speed_o(acur[5:4]),
      .lower_threshold_o(acur[3:0]),
      .load_filter_enable_o(load[12]), .load_threshold_o(load[11:5]),
      .current_scale_o(load[4:0]),
      .test_bit_o(dcfg[11]), .high_side_slope_o(dcfg[10:9]), .low_side_slope_o(dcfg[8:7]),
      .short_to_ground_disable_o(dcfg[6]), .short_timer_o(dcfg[5:4]),
      .step_interface_off_o(dcfg[3]), .sense_voltage_select_o(dcfg[2]),
      .read_select_o(dcfg[1:0])
   );

   function automatic logic [19:0] rsp_exp(input logic [1:0] s);
      case (s)
         2'b00: return {pos, 2'b00, flags};
         2'b01: return {ld, 10'h000};
         2'b10: return {ld[9:5], lvl, 10'h000};
         default: return 20'h00000;
      endcase
   endfunction

   task settle(input int k);
      repeat (k) @(posedge clk);
      #1;
   endtask

   task chk_all();
      `CHK("coil", e_coil[17:0], coil)
      `CHK("step", {e_step[9:8], e_step[3:0]}, stp)
      `CHK("chop", e_chop[16:0], chop)
      `CHK("acur", {e_acur[15:13], e_acur[11:8], e_acur[6:5], e_acur[3:0]}, acur)
      `CHK("load", {e_load[16], e_load[14:8], e_load[4:0]}, load)
      `CHK("dcfg", {e_dcfg[16:12], e_dcfg[10:4]}, dcfg)
   endtask

   task automatic wr(input logic [31:0] d, input int n);
      logic [19:0] er;
      er = rsp_exp(e_dcfg[5:4]);
      m.cs_low();
      m.xfer(d, n, rsp);
      settle(6);
      `CHK("oe_n", 1'b0, sdo_oe_n)
      chk_all();
      m.cs_high();
      `CHK("rsp", er, rsp[n-1 -: 20])
      casez (d[19:17])
         3'b00?: begin
            if (e_dcfg[7]) begin
               e_coil = d[19:0];
            end else begin
               e_step = d[19:0];
            end
         end
         3'b100: e_chop = d[19:0];
         3'b101: e_acur = d[19:0];
         3'b110: e_load = d[19:0];
         3'b111: e_dcfg = d[19:0];
         default: ;
      endcase
      settle(2);
      `CHK("oe_n", 1'b1, sdo_oe_n)
      chk_all();
   endtask

   task results();
      $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
      if (error_cnt == 0 && cmp_count > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   initial begin
      #200000;
      error_cnt++;
      $display("ERROR watchdog expected done seen hang");
      results();
   end

   initial begin
      repeat (20) @(posedge clk);
      rst_n <= 1'b1;
      settle(4);
      chk_all();
      `CHK("oe_n", 1'b1, sdo_oe_n)
      @(posedge clk);
      pos <= 10'h2a5;
      ld <= 10'h1c3;
      lvl <= 5'h16;
      flags <= 8'ha5;
      settle(1);
      for (int k = 1; k <= 4; k++) begin
         wr({12'h000, 3'b111, 5'b10110, 2'b01, 2'b10, 2'b10, k[1:0], 4'h0}, 20);
      end
      wr({12'h000, 2'b00, 18'h2b5c3}, 20);
      wr(32'h000e0000, 20);
      wr({12'h000, 2'b00, 8'h00, 2'b11, 4'h0, 4'h7}, 20);
      wr({12'h000, 3'b100, 17'h1a5f3}, 20);
      wr({12'h000, 4'b1010, 3'b101, 1'b0, 4'hb, 1'b0, 2'b10, 1'b0, 4'h6}, 20);
      wr({12'h000, 3'b110, 2'b10, 7'h55, 3'b000, 5'h13}, 20);
      wr({12'h000, 2'b01, 18'h3ffff}, 20);
      wr({8'h00, 4'h9, 3'b100, 17'h0a5c6}, 24);
      `CHK("chain", 4'h9, rsp[3:0])
      // Mid-run reset clears every stored word
      @(posedge clk);
      rst_n <= 1'b0;
      repeat (4) @(posedge clk);
      rst_n <= 1'b1;
      e_coil = '0;
      e_step = '0;
      e_chop = '0;
      e_acur = '0;
      e_load = '0;
      e_dcfg = '0;
      settle(4);
      chk_all();
      wr({12'h000, 3'b101, 17'h0a265}, 20);
      results();
   end
endmodule
